// ### rtl/lcd_drive_consts.svh
// constants of the multiplexed lcd drive timing block
`ifndef LCD_DRIVE_CONSTS_SVH
`define LCD_DRIVE_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_RAM0 8'h08
`define RAM_WORDS 5

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define CTRL_MODE_LSB 0
`define CTRL_BIAS_BIT 2
`define CTRL_EN_BIT 3
`define RST_MODE 2'h3
`define RST_BIAS_HALF 1'b1
`define RST_EN 1'b0

// ----------------------------------------
// timing and levels
// ----------------------------------------
`define FRAME_DIV 24
`define HALF_DIV 12
`define LVL_VSS 2'h0
`define LVL_LOW 2'h1
`define LVL_HIGH 2'h2
`define LVL_VLCD 2'h3

`endif

// ### rtl/lcd_drive_pkg.sv
// types of the multiplexed lcd drive timing block
package lcd_drive_pkg;

	typedef enum logic [1:0] {
		MODE_STATIC = 2'h0,
		MODE_MUX2 = 2'h1,
		MODE_MUX3 = 2'h2,
		MODE_MUX4 = 2'h3
	} mode_type;

	// gray order along the phase walk
	typedef enum logic [1:0] {
		PH0 = 2'h0,
		PH1 = 2'h1,
		PH2 = 2'h3,
		PH3 = 2'h2
	} phase_type;

	typedef struct packed {
		logic [3:0][1:0] bp;
		logic [39:0][1:0] seg;
	} drive_type;

	typedef struct packed {
		mode_type mode;
		logic bias_half;
		logic enable;
	} config_type;

endpackage

// ### rtl/lcd_drive.sv
// multiplexed lcd drive timing, latch and level selection with wishbone registers
`timescale 1ns/1ps
`include "lcd_drive_consts.svh"

module lcd_drive #(
	parameter int OSC_DIV = 10
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic internal_clock_select_i,
	input wire logic clk_io_i,
	output logic clk_io_o,
	output logic clk_io_oe_n_o,
	input wire logic align_i,
	output logic align_o,
	output logic align_oe_n_o,
	output lcd_drive_pkg::drive_type drive_o
);

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (OSC_DIV < 2 || OSC_DIV % 2 != 0) begin : g_bad_div
		$error("OSC_DIV must be even and at least two");
	end

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// backplane i fed by memory row; extra lines repeat active ones
	function automatic logic [1:0] bp_row(input logic [1:0] i, input lcd_drive_pkg::mode_type m);
		case (m)
			lcd_drive_pkg::MODE_STATIC: bp_row = 2'h0;
			lcd_drive_pkg::MODE_MUX2: bp_row = {1'b0, i[0]};
			lcd_drive_pkg::MODE_MUX3: bp_row = (i == 2'h3) ? 2'h1 : i;
			default: bp_row = i;
		endcase
	endfunction

	function automatic logic [1:0] bp_level(input logic sel, input logic pos, input logic half);
		if (sel)
			bp_level = pos ? `LVL_VLCD : `LVL_VSS;
		else if (half)
			bp_level = `LVL_LOW;
		else
			bp_level = pos ? `LVL_LOW : `LVL_HIGH;
	endfunction

	function automatic logic [1:0] seg_level(input logic on, input logic pos, input logic half);
		if (on)
			seg_level = pos ? `LVL_VSS : `LVL_VLCD;
		else if (half)
			seg_level = pos ? `LVL_VLCD : `LVL_VSS;
		else
			seg_level = pos ? `LVL_HIGH : `LVL_LOW;
	endfunction

	function automatic logic [3:0] phase_len(input lcd_drive_pkg::mode_type m);
		case (m)
			lcd_drive_pkg::MODE_STATIC: phase_len = 4'd12;
			lcd_drive_pkg::MODE_MUX2: phase_len = 4'd6;
			lcd_drive_pkg::MODE_MUX3: phase_len = 4'd4;
			default: phase_len = 4'd3;
		endcase
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	lcd_drive_pkg::config_type cfg;
	logic [39:0][3:0] ram;
	logic [39:0][3:0] latch;
	logic [4:0] cnt;
	logic [3:0] sub;
	lcd_drive_pkg::phase_type phase;
	logic tick;
	logic ext_sel;
	logic [5:0] wadr;
	logic req;

	assign wadr = adr_i[7:2];
	assign req = cyc_i & stb_i & ~ack_o;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg.mode <= lcd_drive_pkg::mode_type'(`RST_MODE);
			cfg.bias_half <= `RST_BIAS_HALF;
			cfg.enable <= `RST_EN;
		end else if (req && we_i && adr_i == `OFS_CTRL && sel_i[0]) begin
			cfg.mode <= lcd_drive_pkg::mode_type'(dat_i[`CTRL_MODE_LSB +: 2]);
			cfg.bias_half <= dat_i[`CTRL_BIAS_BIT];
			cfg.enable <= dat_i[`CTRL_EN_BIT];
		end
	end

	// each byte lane carries two columns of four rows
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ram <= '0;
		end else if (req && we_i && wadr >= 6'(`OFS_RAM0 >> 2)) begin
			for (int w = 0; w < `RAM_WORDS; w++) begin
				for (int b = 0; b < 4; b++) begin
					if (wadr == 6'((`OFS_RAM0 >> 2) + w) && sel_i[b]) begin
						ram[8 * w + 2 * b] <= dat_i[8 * b +: 4];
						ram[8 * w + 2 * b + 1] <= dat_i[8 * b + 4 +: 4];
					end
				end
			end
		end
	end

	// unmapped reads answer zero, writes there are dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= '0;
		end else begin
			ack_o <= req;
			dat_o <= '0;
			if (req && !we_i) begin
				if (adr_i == `OFS_CTRL)
					dat_o <= {28'h0, cfg.enable, cfg.bias_half, cfg.mode};
				else if (adr_i == `OFS_STATUS)
					dat_o <= {20'h0, ext_sel, phase, sub, cnt};
				else
					for (int w = 0; w < `RAM_WORDS; w++)
						if (wadr == 6'((`OFS_RAM0 >> 2) + w))
							dat_o <= ram[8 * w +: 8];
			end
		end
	end

	// ----------------------------------------
	// clock source
	// ----------------------------------------
	logic [1:0] sel_sync;
	logic [2:0] clk_sync;
	logic [1:0] align_sync;
	logic [$clog2(OSC_DIV) - 1:0] osc_cnt;
	logic osc_tick;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sel_sync <= '0;
			clk_sync <= '0;
			align_sync <= 2'h3;
		end else begin
			sel_sync <= {sel_sync[0], internal_clock_select_i};
			clk_sync <= {clk_sync[1:0], clk_io_i};
			align_sync <= {align_sync[0], align_i};
		end
	end

	assign ext_sel = sel_sync[1];

	// internal oscillator stands in as a divider of clk_i
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			osc_cnt <= '0;
			clk_io_o <= 1'b0;
		end else if (osc_cnt == ($clog2(OSC_DIV))'(OSC_DIV / 2 - 1)) begin
			osc_cnt <= '0;
			clk_io_o <= ~clk_io_o;
		end else begin
			osc_cnt <= osc_cnt + 1'b1;
		end
	end

	assign osc_tick = (osc_cnt == ($clog2(OSC_DIV))'(OSC_DIV / 2 - 1)) && !clk_io_o;
	// tick on the rising edge of whichever clock is active
	assign tick = ext_sel ? (clk_sync[1] & ~clk_sync[2]) : osc_tick;
	assign clk_io_oe_n_o = ext_sel;

	// ----------------------------------------
	// frame timing
	// ----------------------------------------
	logic align_low;
	logic frame_end;

	// a neighbour pulling the line while we sit elsewhere drags us to its frame start
	assign align_low = ~align_sync[1] && cnt != 5'd0;
	assign frame_end = tick && !align_low && cnt == 5'(`FRAME_DIV - 1);
	assign align_o = 1'b0;
	assign align_oe_n_o = (cnt != 5'd0);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= '0;
			sub <= '0;
			phase <= lcd_drive_pkg::PH0;
		end else if (tick) begin
			if (align_low) begin
				cnt <= 5'd1;
				sub <= 4'd1;
				phase <= lcd_drive_pkg::PH0;
			end else if (frame_end || cnt == 5'(`HALF_DIV - 1)) begin
				cnt <= frame_end ? 5'd0 : cnt + 1'b1;
				sub <= '0;
				phase <= lcd_drive_pkg::PH0;
			end else if (sub >= phase_len(cfg.mode) - 1'b1) begin
				cnt <= cnt + 1'b1;
				sub <= '0;
				case (phase)
					lcd_drive_pkg::PH0: phase <= lcd_drive_pkg::PH1;
					lcd_drive_pkg::PH1: phase <= lcd_drive_pkg::PH2;
					lcd_drive_pkg::PH2: phase <= lcd_drive_pkg::PH3;
					default: phase <= lcd_drive_pkg::PH0;
				endcase
			end else begin
				cnt <= cnt + 1'b1;
				sub <= sub + 1'b1;
			end
		end
	end

	// copying only at the frame edge keeps both polarities of a frame on one image
	always_ff @(posedge clk_i) begin
		if (rst_i)
			latch <= '0;
		else if (frame_end || (tick && align_low))
			latch <= ram;
	end

	// ----------------------------------------
	// level selection
	// ----------------------------------------
	lcd_drive_pkg::drive_type next_drive;
	logic [1:0] row;
	logic pos;
	logic half;

	always_comb begin
		case (phase)
			lcd_drive_pkg::PH0: row = 2'h0;
			lcd_drive_pkg::PH1: row = 2'h1;
			lcd_drive_pkg::PH2: row = 2'h2;
			default: row = 2'h3;
		endcase
	end

	assign pos = (cnt < 5'(`HALF_DIV));
	assign half = cfg.bias_half || cfg.mode == lcd_drive_pkg::MODE_STATIC;

	always_comb begin
		next_drive = '1;
		if (cfg.enable) begin
			for (int i = 0; i < 4; i++)
				next_drive.bp[i] = bp_level(bp_row(2'(i), cfg.mode) == row, pos, half);
			for (int c = 0; c < 40; c++)
				next_drive.seg[c] = seg_level(latch[c][row], pos, half);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			drive_o <= '1;
		else
			drive_o <= next_drive;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence bus_req_s;
		cyc_i && stb_i && !ack_o;
	endsequence

	sequence bus_ack_s;
		ack_o ##1 !ack_o;
	endsequence

	chk_bus_ack: assert property (bus_req_s |=> bus_ack_s)
		else $error("wishbone ack not a single cycle after request");

	chk_frame_wrap: assert property (frame_end |=> cnt == 5'd0 && phase == lcd_drive_pkg::PH0)
		else $error("frame did not wrap after twenty four ticks");

	chk_reset_cfg: assert property ($past(rst_i) |-> cfg.mode == lcd_drive_pkg::MODE_MUX4 && cfg.bias_half && !cfg.enable)
		else $error("reset configuration wrong");

	chk_disabled_lvl: assert property (!cfg.enable |=> drive_o == '1)
		else $error("disabled display not at full supply");

	chk_mux3_pair: assert property ($past(cfg.mode) == lcd_drive_pkg::MODE_MUX3 |-> drive_o.bp[3] == drive_o.bp[1])
		else $error("backplane four differs from two in 1:3");

	chk_mux2_pair: assert property ($past(cfg.mode) == lcd_drive_pkg::MODE_MUX2 |-> drive_o.bp[2] == drive_o.bp[0] && drive_o.bp[3] == drive_o.bp[1])
		else $error("backplane pairs differ in 1:2");

	chk_static_same: assert property ($past(cfg.mode) == lcd_drive_pkg::MODE_STATIC |-> drive_o.bp[1] == drive_o.bp[0] && drive_o.bp[2] == drive_o.bp[0] && drive_o.bp[3] == drive_o.bp[0])
		else $error("static backplanes differ");

	chk_latch_hold: assert property (!frame_end && !(tick && align_low) |=> $stable(latch))
		else $error("latch changed inside a frame");

	chk_clk_drive: assert property (!ext_sel && tick |=> clk_io_o && !clk_io_oe_n_o)
		else $error("internal tick not on a driven rising clock pin");

	chk_align_drive: assert property (tick && !align_low && cnt == 5'd0 |=> align_oe_n_o)
		else $error("align line held past frame start");

	chk_polarity: assert property ($past(cfg.enable) && $past(pos) && $past(phase) == lcd_drive_pkg::PH0 && $past(cfg.mode) == lcd_drive_pkg::MODE_MUX4 |-> drive_o.bp[0] == `LVL_VLCD)
		else $error("selected backplane not at supply in positive half");

endmodule // lcd_drive

// ### bench/lcd_far_side.sv
// far side model: cascade clock source and shared align line with pull-up
`timescale 1ns/1ps
module lcd_far_side #(
	parameter int EXT_HALF = 8
) (
	input wire logic clk_i,
	input wire logic dev_clk_i,
	input wire logic dev_clk_oe_n_i,
	input wire logic dev_align_oe_n_i,
	input wire logic pull_low_i,
	output logic clk_line_o,
	output logic align_line_o
);
	int cnt = 0;
	logic ext_clk = 1'b0;
	// the far clock never stops: a halted clock would leave dc on the glass
	always @(posedge clk_i) begin
		cnt <= (cnt == EXT_HALF - 1) ? 0 : cnt + 1;
		if (cnt == EXT_HALF - 1)
			ext_clk <= ~ext_clk;
	end
	assign clk_line_o = dev_clk_oe_n_i ? ext_clk : dev_clk_i;
	// open drain: any party pulling low wins
	assign align_line_o = dev_align_oe_n_i & ~pull_low_i;
endmodule // lcd_far_side

// ### bench/lcd_drive_tb_top.sv
// self-checking bench of the lcd drive block
`timescale 1ns/1ps
module lcd_drive_tb_top;
	localparam int DIV = 10;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, sel_clk = 1'b0, pull_low = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rdat, dat_o;
	logic ack_o, clk_io_o, clk_io_oe_n_o, align_oe_n_o, clk_line, align_line;
	logic [3:0] ctl;
	logic [3:0] ram [40];
	lcd_drive_pkg::drive_type drive_o;
	int num_errors = 0;
	int n_checks = 0;
	int n;
	always #25 clk_i = ~clk_i;
	lcd_drive #(.OSC_DIV(DIV)) lcd_drive_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dat_o),
		.ack_o(ack_o), .internal_clock_select_i(sel_clk), .clk_io_i(clk_line),
		.clk_io_o(clk_io_o), .clk_io_oe_n_o(clk_io_oe_n_o), .align_i(align_line),
		.align_o(), .align_oe_n_o(align_oe_n_o), .drive_o(drive_o));
	lcd_far_side lcd_far_side_inst (.clk_i(clk_i), .dev_clk_i(clk_io_o),
		.dev_clk_oe_n_i(clk_io_oe_n_o), .dev_align_oe_n_i(align_oe_n_o),
		.pull_low_i(pull_low), .clk_line_o(clk_line), .align_line_o(align_line));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [87:0] seen, input logic [87:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (ack_o !== 1'b1 && i < 50);
		if (i >= 50) begin
			check(1, 0);
			end_of_test();
		end
		rdat = dat_o;
		{cyc, stb} <= 2'b00;
	endtask
	task automatic wait_fall(output int cnt);
		logic prev;
		cnt = 0;
		forever begin
			prev = align_oe_n_o;
			@(posedge clk_i);
			cnt++;
			if (prev === 1'b1 && align_oe_n_o === 1'b0)
				return;
			if (cnt > 5000) begin
				check(1, 0);
				end_of_test();
			end
		end
	endtask
	function automatic lcd_drive_pkg::drive_type expect_drv(input logic [31:0] st);
		int m, p, r;
		logic neg, half;
		lcd_drive_pkg::drive_type e;
		m = ctl[1:0] + 1;
		// static mode only has two levels, so it is scored as half bias
		half = ctl[2] | (ctl[1:0] == 2'h0);
		neg = st[4:0] >= 5'd12;
		p = (st[4:0] % 12) / (12 / m);
		for (int i = 0; i < 4; i++) begin
			r = (m == 1) ? 0 : (m == 2) ? i % 2 : (m == 3 && i == 3) ? 1 : i;
			e.bp[i] = (r == p) ? (neg ? 2'h0 : 2'h3) : (neg && !half) ? 2'h2 : 2'h1;
		end
		for (int k = 0; k < 40; k++)
			e.seg[k] = ram[k][p] ? (neg ? 2'h3 : 2'h0) : (neg ? {1'b0, !half} : {1'b1, half});
		return e;
	endfunction
	task automatic sample_levels();
		logic [31:0] s1;
		lcd_drive_pkg::drive_type d;
		wb(1'b0, 8'h04, 32'h0);
		s1 = rdat;
		@(posedge clk_i);
		d = drive_o;
		wb(1'b0, 8'h04, 32'h0);
		// a tick between the two reads makes the sample ambiguous, so it is dropped
		if (rdat[4:0] === s1[4:0])
			check(d, expect_drv(s1));
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] w;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		check(drive_o, '1);
		wb(1'b0, 8'h00, 32'h0);
		check(rdat, 32'h7);
		wb(1'b1, 8'h40, 32'hffffffff);
		wb(1'b0, 8'h40, 32'h0);
		check(rdat, 32'h0);
		for (int k = 0; k < 5; k++) begin
			w = 32'h9f3c61a5 + 32'h13572468 * k;
			wb(1'b1, 8'h08 + 8'(4 * k), w);
			for (int j = 0; j < 8; j++)
				ram[8 * k + j] = w[4 * j +: 4];
		end
		check(clk_io_oe_n_o, 0);
		wait_fall(n);
		wait_fall(n);
		check(n, 24 * DIV);
		$display("test reset and frame rate done");
		for (int c = 0; c < 8; c++) begin
			ctl = {1'b1, c[0], c[2:1]};
			wb(1'b1, 8'h00, {28'h0, ctl});
			// a mode change leaves the phase walk stale until the next half-frame start
			wait_fall(n);
			repeat (12) sample_levels();
		end
		$display("test modes and bias done");
		ctl = 4'hb;
		wb(1'b1, 8'h00, {28'h0, ctl});
		wait_fall(n);
		wb(1'b1, 8'h08, ~w);
		repeat (3) sample_levels();
		for (int j = 0; j < 8; j++)
			ram[j] = ~w[4 * j +: 4];
		wait_fall(n);
		repeat (3) sample_levels();
		wb(1'b1, 8'h00, 32'h3);
		repeat (2) @(posedge clk_i);
		check(drive_o, '1);
		$display("test latch and disable done");
		repeat (100) @(posedge clk_i);
		pull_low <= 1'b1;
		repeat (DIV) @(posedge clk_i);
		pull_low <= 1'b0;
		repeat (30) @(posedge clk_i);
		wb(1'b0, 8'h04, 32'h0);
		check(rdat[4:0] < 5'd8, 1);
		sel_clk <= 1'b1;
		repeat (3) wait_fall(n);
		check(n, 24 * 16);
		check(clk_io_oe_n_o, 1);
		wb(1'b0, 8'h04, 32'h0);
		check(rdat[11], 1);
		$display("test cascade and external clock done");
		end_of_test();
	end
endmodule // lcd_drive_tb_top
